// *** hw/fsup_pkg.sv ***
package fsup_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned TRIP_TIME_MS    = 1000;
  localparam int unsigned RECOVER_TIME_MS = 30000;
  localparam int unsigned MAINS_TIME_MS   = 1000;
  localparam int unsigned BEEP_TIME_MS    = 250;
  localparam int unsigned TRIP_CYCLES    = CLK_HZ / 1000 * TRIP_TIME_MS;
  localparam int unsigned RECOVER_CYCLES = CLK_HZ / 1000 * RECOVER_TIME_MS;
  localparam int unsigned MAINS_CYCLES   = CLK_HZ / 1000 * MAINS_TIME_MS;
  localparam int unsigned BEEP_CYCLES    = CLK_HZ / 1000 * BEEP_TIME_MS;

  localparam int CNT_W = 31;

  // temperature in whole degrees c, unsigned
  localparam int TEMP_W = 8;
  localparam logic [TEMP_W-1:0] TRIP_TEMP_C    = 8'h50;
  localparam logic [TEMP_W-1:0] RECOVER_TEMP_C = 8'h46;

  // displayed fault code, zero when none
  typedef enum logic [3:0] {
    FSUP_CODE_NONE,
    FSUP_CODE_MAINS_UNDERVOLTAGE_WARNING,
    FSUP_CODE_MAINS_OVERVOLTAGE,
    FSUP_CODE_MAINS_SEVERE_UNDERVOLTAGE,
    FSUP_CODE_DIODE_OVERTEMP,
    FSUP_CODE_TRANSISTOR_OVERTEMP,
    FSUP_CODE_OUTPUT_OVERVOLTAGE,
    FSUP_CODE_PRIMARY_OVERCURRENT
  } fsup_code_type;

  typedef struct packed {
    logic transistor_overtemp;
    logic diode_overtemp;
    logic primary_overcurrent;
    logic output_overvoltage;
    logic mains_overvoltage;
    logic mains_severe_undervoltage;
    logic mains_undervoltage_warning;
  } fsup_faults_type;

  localparam fsup_faults_type FAULTS_RESET = '0;

endpackage

// *** hw/fsup_top.sv ***
// Functional notes
// (R1) transistor sink above 80C for 1 s: code, stop current, buzzer constant, fan max
// (R2) diode sink above 80C for 1 s: code, stop current, buzzer constant, fan max
// (R3) thermal fault clears only after its sensor stays at or below 70C for 30 s
// (R4) primary overcurrent or output overvoltage: code, stop, buzzer; latched until power cycle
// (R5) capacitor voltage over nominal+10% for 1 s: code, stop, buzzer; self-clearing
// (R6) mains under nominal-10% for 1 s: warning code, beeping buzzer, current kept
// (R7) mains dangerously low for 1 s: code, stop, buzzer constant; self-clearing
// (R8) show most severe active code; current stays off while any stopping fault
`timescale 1ns/1ps
`default_nettype none
module fsup_top #(
  parameter int unsigned TRIP_CYCLES_P    = fsup_pkg::TRIP_CYCLES,
  parameter int unsigned RECOVER_CYCLES_P = fsup_pkg::RECOVER_CYCLES,
  parameter int unsigned MAINS_CYCLES_P   = fsup_pkg::MAINS_CYCLES,
  parameter int unsigned BEEP_CYCLES_P    = fsup_pkg::BEEP_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [fsup_pkg::TEMP_W-1:0]   transistor_temp_sensor,
  input  wire logic [fsup_pkg::TEMP_W-1:0]   diode_temp_sensor,
  input  wire logic                          primary_overcurrent,
  input  wire logic                          output_overvoltage,
  input  wire logic                          cap_overvoltage,
  input  wire logic                          mains_low,
  input  wire logic                          mains_danger_low,
  output logic                               weld_enable,
  output logic                               buzzer,
  output logic                               fan_max,
  output fsup_pkg::fsup_code_type            fault_code,
  output fsup_pkg::fsup_faults_type          faults
);

  localparam int N = 5;  // qualified conditions with timers

  // all sensor and comparator inputs are asynchronous to clk: two stages each; nrst is used unsynced
  logic [fsup_pkg::TEMP_W-1:0] t1_s1_q, t1_s2_q, t2_s1_q, t2_s2_q;
  logic [4:0]                  cmp_s1_q, cmp_s2_q;
  // sensor words are synced bit by bit, so one caught mid-change is garbage;
  // a word is only taken once two synced samples agree
  logic [fsup_pkg::TEMP_W-1:0] t1_s3_q, t2_s3_q, t1_q, t1_d, t2_q, t2_d;

  always_ff @(posedge clk) begin
    t1_s1_q  <= transistor_temp_sensor;
    t1_s2_q  <= t1_s1_q;
    t1_s3_q  <= t1_s2_q;
    t2_s1_q  <= diode_temp_sensor;
    t2_s2_q  <= t2_s1_q;
    t2_s3_q  <= t2_s2_q;
    t1_q     <= t1_d;
    t2_q     <= t2_d;
    cmp_s1_q <= {mains_danger_low, mains_low, cap_overvoltage, output_overvoltage, primary_overcurrent};
    cmp_s2_q <= cmp_s1_q;
  end

  // limitation: a sensor word that moves on every clock is never taken;
  // real heat sinks change far slower than that
  always_comb begin
    t1_d = t1_q;
    t2_d = t2_q;
    if (t1_s2_q == t1_s3_q) begin
      t1_d = t1_s2_q;
    end
    if (t2_s2_q == t2_s3_q) begin
      t2_d = t2_s2_q;
    end
  end

  function automatic logic temp_over_trip(input logic [fsup_pkg::TEMP_W-1:0] t);
    return t > fsup_pkg::TRIP_TEMP_C;
  endfunction

  function automatic logic temp_recovered(input logic [fsup_pkg::TEMP_W-1:0] t);
    return t <= fsup_pkg::RECOVER_TEMP_C;
  endfunction

  // qualify-set and qualify-clear timers per condition
  // index: 0 transistor temp, 1 diode temp, 2 cap over, 3 mains low, 4 mains danger
  logic [N-1:0] raw_hi, raw_lo, act_q, act_d;
  logic [fsup_pkg::CNT_W-1:0] cnt_q [N];
  logic [fsup_pkg::CNT_W-1:0] cnt_d [N];
  logic [fsup_pkg::CNT_W-1:0] set_lim [N];
  logic [fsup_pkg::CNT_W-1:0] clr_lim [N];

  always_comb begin
    raw_hi[0] = temp_over_trip(t1_q);  // [R1]
    raw_lo[0] = temp_recovered(t1_q);  // [R3]
    raw_hi[1] = temp_over_trip(t2_q);  // [R2]
    raw_lo[1] = temp_recovered(t2_q);  // [R3]
    raw_hi[2] = cmp_s2_q[2];
    raw_lo[2] = !cmp_s2_q[2];
    raw_hi[3] = cmp_s2_q[3];
    raw_lo[3] = !cmp_s2_q[3];
    raw_hi[4] = cmp_s2_q[4];
    raw_lo[4] = !cmp_s2_q[4];
    set_lim[0] = fsup_pkg::CNT_W'(TRIP_CYCLES_P - 1);
    set_lim[1] = fsup_pkg::CNT_W'(TRIP_CYCLES_P - 1);
    clr_lim[0] = fsup_pkg::CNT_W'(RECOVER_CYCLES_P - 1);  // [R3]
    clr_lim[1] = fsup_pkg::CNT_W'(RECOVER_CYCLES_P - 1);
    for (int i = 2; i < N; i++) begin
      set_lim[i] = fsup_pkg::CNT_W'(MAINS_CYCLES_P - 1);  // [R5] [R6] [R7]
      // mains faults clear as soon as the voltage is back
      clr_lim[i] = '0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_qual
      always_comb begin
        act_d[g] = act_q[g];
        cnt_d[g] = '0;
        if (!act_q[g]) begin
          // any drop below threshold restarts the one second count
          if (raw_hi[g]) begin
            if (cnt_q[g] >= set_lim[g]) begin
              act_d[g] = 1'b1;
            end else begin
              cnt_d[g] = cnt_q[g] + 1'b1;
            end
          end
        end else if (raw_lo[g]) begin
          if (cnt_q[g] >= clr_lim[g]) begin
            act_d[g] = 1'b0;
          end else begin
            cnt_d[g] = cnt_q[g] + 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      act_q <= '0;
      for (int i = 0; i < N; i++) cnt_q[i] <= '0;
    end else begin
      act_q <= act_d;
      for (int i = 0; i < N; i++) cnt_q[i] <= cnt_d[i];
    end
  end

  // power-cycle latched faults: only nrst clears them
  logic [1:0] latch_q, latch_d;
  always_comb begin
    latch_d = latch_q | cmp_s2_q[1:0];  // [R4]
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      latch_q <= '0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // most severe first: latched, then thermal, then mains
  function automatic fsup_pkg::fsup_code_type worst_code(input fsup_pkg::fsup_faults_type f);
    if (f.primary_overcurrent)             return fsup_pkg::FSUP_CODE_PRIMARY_OVERCURRENT;
    else if (f.output_overvoltage)         return fsup_pkg::FSUP_CODE_OUTPUT_OVERVOLTAGE;
    else if (f.transistor_overtemp)        return fsup_pkg::FSUP_CODE_TRANSISTOR_OVERTEMP;
    else if (f.diode_overtemp)             return fsup_pkg::FSUP_CODE_DIODE_OVERTEMP;
    else if (f.mains_severe_undervoltage)  return fsup_pkg::FSUP_CODE_MAINS_SEVERE_UNDERVOLTAGE;
    else if (f.mains_overvoltage)          return fsup_pkg::FSUP_CODE_MAINS_OVERVOLTAGE;
    else if (f.mains_undervoltage_warning) return fsup_pkg::FSUP_CODE_MAINS_UNDERVOLTAGE_WARNING;
    else                                   return fsup_pkg::FSUP_CODE_NONE;
  endfunction

  fsup_pkg::fsup_faults_type f_d;
  fsup_pkg::fsup_code_type   code_d;
  logic                      stop_d, beep_d, fan_d;
  logic [fsup_pkg::CNT_W-1:0] beep_cnt_q, beep_cnt_d;
  logic                      beep_ph_q, beep_ph_d;

  always_comb begin
    f_d.transistor_overtemp        = act_d[0];
    f_d.diode_overtemp             = act_d[1];
    f_d.mains_overvoltage          = act_d[2];
    f_d.mains_undervoltage_warning = act_d[3];
    f_d.mains_severe_undervoltage  = act_d[4];
    f_d.primary_overcurrent        = latch_d[0];
    f_d.output_overvoltage         = latch_d[1];
    code_d = worst_code(f_d);  // [R8]
    stop_d = f_d.transistor_overtemp | f_d.diode_overtemp | f_d.primary_overcurrent
           | f_d.output_overvoltage | f_d.mains_overvoltage | f_d.mains_severe_undervoltage;  // [R1] [R2] [R4] [R5] [R7] [R8]
    fan_d  = f_d.transistor_overtemp | f_d.diode_overtemp;  // [R1] [R2]
    beep_cnt_d = '0;
    beep_ph_d  = 1'b0;
    if (f_d.mains_undervoltage_warning) begin
      beep_ph_d = beep_ph_q;
      if (beep_cnt_q >= fsup_pkg::CNT_W'(BEEP_CYCLES_P - 1)) begin
        beep_ph_d = !beep_ph_q;
      end else begin
        beep_cnt_d = beep_cnt_q + 1'b1;
      end
    end
    // a stopping fault overrides the intermittent pattern
    beep_d = stop_d | beep_ph_d;  // [R6]
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      beep_cnt_q  <= '0;
      beep_ph_q   <= 1'b0;
      weld_enable <= 1'b0;
      buzzer      <= 1'b0;
      fan_max     <= 1'b0;
      fault_code  <= fsup_pkg::FSUP_CODE_NONE;
      faults      <= fsup_pkg::FAULTS_RESET;
    end else begin
      beep_cnt_q  <= beep_cnt_d;
      beep_ph_q   <= beep_ph_d;
      weld_enable <= !stop_d;  // [R6]
      buzzer      <= beep_d;
      fan_max     <= fan_d;
      fault_code  <= code_d;
      faults      <= f_d;
    end
  end

endmodule
`default_nettype wire

// *** verification/fsup_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsup_props #(
  parameter int unsigned TRIP_CYCLES_P    = 8,
  parameter int unsigned RECOVER_CYCLES_P = 16
) (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic [7:0]                transistor_temp_sensor,
  input wire logic                      primary_overcurrent,
  input wire logic                      output_overvoltage,
  input wire logic                      cap_overvoltage,
  input wire logic                      weld_enable,
  input wire logic                      buzzer,
  input wire logic                      fan_max,
  input wire fsup_pkg::fsup_code_type   fault_code,
  input wire fsup_pkg::fsup_faults_type faults
);
  logic [31:0] hot_q, hot_d, cool_q, cool_d;
  // raw counts lead the sync stages, so a compliant trip always sees >=
  always_comb begin
    hot_d = (transistor_temp_sensor > fsup_pkg::TRIP_TEMP_C) ? hot_q + 32'(hot_q != '1) : '0;
    cool_d = (transistor_temp_sensor <= fsup_pkg::RECOVER_TEMP_C) ? cool_q + 32'(cool_q != '1) : '0;
  end
  always_ff @(posedge clk) begin
    hot_q <= nrst ? hot_d : '0;
    cool_q <= nrst ? cool_d : '0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence cap_gone; (!cap_overvoltage) [*6]; endsequence
  sequence stop_set; (faults & 7'h7e) != 7'h00; endsequence
  oc_latch_a: assert property (primary_overcurrent |-> ##[1:4] faults.primary_overcurrent) else $error("oc late");
  ov_latch_a: assert property (output_overvoltage |-> ##[1:4] faults.output_overvoltage) else $error("ov late");
  latch_hold_a: assert property (faults.primary_overcurrent |=> faults.primary_overcurrent) else $error("oc lost");
  stop_out_a: assert property (stop_set |-> !weld_enable && buzzer) else $error("no stop");
  fan_therm_a: assert property (faults[6:5] != 2'b00 |-> fan_max && buzzer) else $error("fan low");
  trip_time_a: assert property ($rose(faults.transistor_overtemp) |-> hot_q >= TRIP_CYCLES_P) else $error("trip early");
  recover_a: assert property ($fell(faults.transistor_overtemp) |-> cool_q >= RECOVER_CYCLES_P) else $error("clr early");
  cap_clear_a: assert property (cap_gone |-> !faults.mains_overvoltage) else $error("ovv stuck");
  code_prio_a: assert property (faults.primary_overcurrent |-> fault_code == fsup_pkg::FSUP_CODE_PRIMARY_OVERCURRENT)
    else $error("bad code");
endmodule
bind fsup_top fsup_props #(.TRIP_CYCLES_P(TRIP_CYCLES_P), .RECOVER_CYCLES_P(RECOVER_CYCLES_P)) u_fsup_props (
  .clk, .nrst, .transistor_temp_sensor, .primary_overcurrent, .output_overvoltage,
  .cap_overvoltage, .weld_enable, .buzzer, .fan_max, .fault_code, .faults);
`default_nettype wire

// *** verification/fsup_sense.sv ***
`timescale 1ns/1ps
`default_nettype none
module fsup_sense (
  input  wire logic       clk,
  input  wire logic [7:0] m,
  input  wire logic [7:0] t_tgt,
  input  wire logic [7:0] d_tgt,
  output logic      [7:0] transistor_temp_sensor = 8'h19,
  output logic      [7:0] diode_temp_sensor = 8'h19,
  output logic            primary_overcurrent,
  output logic            output_overvoltage,
  output logic            cap_overvoltage,
  output logic            mains_low,
  output logic            mains_danger_low
);
  // sinks drift a degree a cycle, never jump
  always @(negedge clk) begin
    transistor_temp_sensor <= transistor_temp_sensor + 8'(t_tgt > transistor_temp_sensor) - 8'(t_tgt < transistor_temp_sensor);
    diode_temp_sensor <= diode_temp_sensor + 8'(d_tgt > diode_temp_sensor) - 8'(d_tgt < diode_temp_sensor);
  end
  // a dangerously low mains also sits below the warning level
  assign mains_low = m[1] | m[3];
  assign cap_overvoltage = m[2];
  assign mains_danger_low = m[3];
  assign output_overvoltage = m[6];
  assign primary_overcurrent = m[7];
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, nrst = 1'b0, weld_enable, buzzer, fan_max;
  logic [7:0] m = 8'h00, lat = 8'h00, t_tgt = 8'h19, d_tgt = 8'h19;
  logic [1:0] seen;
  wire logic [7:0] transistor_temp_sensor, diode_temp_sensor;
  wire logic primary_overcurrent, output_overvoltage, cap_overvoltage, mains_low, mains_danger_low;
  fsup_pkg::fsup_code_type code;
  fsup_pkg::fsup_faults_type faults;
  int fail_count = 0, n_compared = 0, cyc = 0, seed = 57056, i;
  fsup_sense u_fsup_sense (.clk, .m, .t_tgt, .d_tgt, .transistor_temp_sensor, .diode_temp_sensor,
    .primary_overcurrent, .output_overvoltage, .cap_overvoltage, .mains_low, .mains_danger_low);
  fsup_top #(.TRIP_CYCLES_P(8), .RECOVER_CYCLES_P(16), .MAINS_CYCLES_P(8), .BEEP_CYCLES_P(4)) u_fsup_top (
    .clk, .nrst, .transistor_temp_sensor, .diode_temp_sensor, .primary_overcurrent, .output_overvoltage,
    .cap_overvoltage, .mains_low, .mains_danger_low, .weld_enable, .buzzer, .fan_max, .fault_code(code), .faults);
  always #12.5 clk = ~clk;
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  function automatic logic [7:0] eff(input logic [7:0] x);
    return x | lat | {6'h00, x[3], 1'b0};
  endfunction
  task automatic chk(input logic [7:0] e);
    logic [6:0] ef;
    logic [3:0] ec;
    ef = {e[5], e[4], e[7], e[6], e[2], e[3], e[1]};
    ec = 4'h0;
    for (int k = 1; k < 8; k++) if (e[k]) ec = 4'(k);
    n_compared++;
    if (faults !== ef || code !== ec || weld_enable !== ~|e[7:2] || fan_max !== |e[5:4]
        || (|e[7:2] && buzzer !== 1'b1) || (~|e[7:1] && buzzer !== 1'b0)) begin
      fail_count++;
      $display("ERROR %0t outputs %h %h for %h", $time, faults, code, e);
    end
  endtask
  task automatic chk_beep(input logic [1:0] s);
    n_compared++;
    if (s !== 2'b11 || weld_enable !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t warning buzzer not beeping", $time);
    end
  endtask
  task automatic apply(input logic [7:0] x, input int n);
    m = x;
    t_tgt = x[5] ? 8'h64 : 8'h19;
    d_tgt = x[4] ? 8'h64 : 8'h19;
    lat |= x & 8'hc0;
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset(input int n);
    nrst = 1'b0;
    apply(8'h00, n);
    lat = 8'h00;
    nrst = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  initial begin
    do_reset(6);
    chk(eff(8'h00));
    for (i = 1; i < 8; i++) begin
      apply(8'h01 << i, 120);
      chk(eff(m));
      apply(8'h00, 120);
      chk(eff(m));
      do_reset(80);
    end
    apply(8'h0e, 5);
    apply(8'h00, 20);
    chk(eff(m));
    apply(8'h02, 40);
    seen = 2'b00;
    repeat (12) begin
      @(negedge clk);
      seen |= buzzer ? 2'b10 : 2'b01;
    end
    chk_beep(seen);
    apply(8'h20, 120);
    t_tgt = 8'h4b;
    repeat (120) @(negedge clk);
    chk(eff(m));
    repeat (6) begin
      apply(8'($random(seed)) & 8'hfe, 120);
      chk(eff(m));
    end
    apply(8'h00, 120);
    chk(eff(m));
    give_verdict();
  end
endmodule
`default_nettype wire
